// ### bench/reset_stop_driver.sv
// far-side model: reset pin and stop pin release circuitry
`timescale 1ns/1ns
`default_nettype none
module reset_stop_driver (
  input wire logic i_clk,
  output logic o_reset_pin_b,
  output logic o_stop_release
);
  // ---------------------------------------------------------------
  // pins idle: reset pulled up, release low
  // ---------------------------------------------------------------
  initial begin
    o_reset_pin_b = 1'b1;
    o_stop_release = 1'b0;
  end
  // ---------------------------------------------------------------
  // pin actions
  // ---------------------------------------------------------------
  task automatic pull_reset(input int mcyc);
    @(posedge i_clk);
    o_reset_pin_b <= 1'b0;
    repeat (mcyc * sbrc_pkg::MCYC_FC) @(posedge i_clk);
    o_reset_pin_b <= 1'b1;
  endtask
  task automatic release_stop();
    @(posedge i_clk);
    o_stop_release <= 1'b1;
    @(posedge i_clk);
    o_stop_release <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### bench/test_standby_and_reset_control.sv
// self-checking bench of the standby and reset controller
`timescale 1ns/1ns
`default_nettype none
module test_standby_and_reset_control;
  import sbrc_pkg::*;
  localparam int W00 = 12;
  localparam int W01 = 8;
  localparam int W10 = 4;
  logic clk, rst_b, cyc, stb, we, ack, rel, pin_b, wrst, wint, ftrap, strap, irq, mst_en;
  logic srst_b, hold, wrun, osc_en, pclr, resume, tirq, vfetch, trap_m;
  logic [7:0] adr;
  logic [3:0] sel, cause_m;
  logic [31:0] wdat, rdat, got;
  logic [19:0] vaddr;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'h5b22;
  int n;
  standby_and_reset_control #(.W00_CYC(W00), .W01_CYC(W01), .W10_CYC(W10))
    u_standby_and_reset_control (.I_MCLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_ACK(ack), .O_WB_DAT(rdat), .I_RESET_PIN_B(pin_b), .I_STOP_RELEASE(rel),
    .I_WDT_RST(wrst), .I_WDT_INT(wint), .I_FETCH_TRAP(ftrap), .I_SOFT_INT_TRAP(strap),
    .I_IRQ_PEND(irq), .I_INT_MASTER_EN(mst_en), .O_SYS_RST_B(srst_b), .O_CPU_HOLD(hold),
    .O_WDT_RUN(wrun), .O_OSC_EN(osc_en), .O_PRESCALER_CLR(pclr), .O_RESUME_NEXT(resume),
    .O_TAKE_IRQ(tirq), .O_VECTOR_FETCH(vfetch), .O_VECTOR_ADDR(vaddr));
  reset_stop_driver u_reset_stop_driver (.i_clk(clk), .o_reset_pin_b(pin_b),
    .o_stop_release(rel));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // compare, bus and model tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_val(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {r[31:8], d};
    do @(posedge clk); while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk_val(nm, e, got);
  endtask
  function automatic logic [31:0] st(input logic [2:0] s);
    return {24'h0, s, trap_m, cause_m};
  endfunction
  task automatic wait_boot();
    n = 0;
    while (vfetch !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit("vector fetch", 1'b1, vfetch);
    chk_val("vector", {12'h0, RST_VECTOR}, {12'h0, vaddr});
    chk_bit("watchdog on", 1'b1, wrun);
    trap_m = 1'b1;
  endtask
  task automatic pin_reset();
    fork
      u_reset_stop_driver.pull_reset(RST_MCYC);
      begin
        @(posedge clk);
        #1;
        chk_bit("pin reset", 1'b0, srst_b);
      end
    join
    wait_boot();
    cause_m[3] = 1'b1;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    int e;
    logic bad;
    {cyc, stb, we, wrst, wint, ftrap, strap, irq, mst_en, rst_b} = '0;
    adr = 8'h00;
    sel = 4'h1;
    wdat = 32'h0;
    cause_m = 4'h0;
    trap_m = 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wait_boot();
    rd("sc1", SC1_OFS, 32'h0);
    rd("sc2", SC2_OFS, 32'h80);
    rd("unmapped", 8'h20, 32'h0);
    rd("status", STAT_OFS, st(3'b000));
    for (int c = 0; c < 4; c++) begin
      r = $random(seed);
      e = (c == 1) ? W01 : (c == 2) ? W10 : W00;
      if (r[0]) e = e * 2;
      wb(1'b1, SC1_OFS, {3'b100, r[0], c[1:0], 2'b00});
      rd("stop state", STAT_OFS, st(3'b001));
      chk_bit("osc off", 1'b0, osc_en);
      chk_bit("prescaler clear", 1'b1, pclr);
      u_reset_stop_driver.release_stop();
      n = 0;
      bad = 1'b0;
      do begin
        @(posedge clk);
        #1;
        n++;
        if (resume !== 1'b1 && (osc_en !== 1'b1 || hold !== 1'b1)) bad = 1'b1;
      end while (resume !== 1'b1 && n < 100);
      chk_val("warm cycles", e, n);
      chk_bit("warm idle", 1'b0, bad);
      chk_bit("prescaler run", 1'b0, pclr);
      rd("sc1 after", SC1_OFS, {24'h0, 3'b000, r[0], c[1:0], 2'b00});
      rd("sc2 after", SC2_OFS, 32'h80);
    end
    wb(1'b1, SC1_OFS, 8'h80);
    pin_reset();
    rd("status pin", STAT_OFS, st(3'b000));
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, SC2_OFS, 8'h90);
      rd("idle state", STAT_OFS, st(3'b010));
      chk_bit("wdt stop", 1'b0, wrun);
      chk_bit("cpu hold", 1'b1, hold);
      rd("idle sc1", SC1_OFS, 32'h0);
      mst_en <= m[0];
      irq <= 1'b1;
      @(posedge clk);
      #1;
      irq <= 1'b0;
      chk_bit("resume", !m[0], resume);
      chk_bit("handler", m[0], tirq);
      rd("sc2 idle", SC2_OFS, 32'h80);
    end
    wint <= 1'b1;
    wb(1'b1, SC2_OFS, 8'h90);
    n = 0;
    bad = 1'b0;
    repeat (3) begin
      #1;
      if (tirq === 1'b1) n++;
      if (hold !== 1'b0) bad = 1'b1;
      @(posedge clk);
    end
    wint <= 1'b0;
    chk_val("wdt irq", 1, n);
    chk_bit("no idle", 1'b0, bad);
    for (int k = 0; k < 5; k++) begin
      if (k == 3) wb(1'b1, SC2_OFS, 8'h00);
      else if (k == 4) wb(1'b1, SC2_OFS, 8'ha0);
      else begin
        @(posedge clk);
        wrst <= (k == 0);
        ftrap <= (k == 1);
        strap <= (k == 2);
        @(posedge clk);
        {wrst, ftrap, strap} <= 3'b000;
      end
      n = 0;
      while (srst_b !== 1'b0 && n < 5) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk_bit("internal reset", 1'b0, srst_b);
      wait_boot();
      cause_m = cause_m | ((k == 0) ? 4'h1 : (k < 3) ? 4'h2 : 4'h4);
      rd("cause", STAT_OFS, st(3'b000));
    end
    wb(1'b1, TPERM_OFS, 8'h01);
    rd("no key", STAT_OFS, st(3'b000));
    wb(1'b1, TKEY_OFS, TRAP_KEY);
    wb(1'b1, TPERM_OFS, 8'h01);
    trap_m = 1'b0;
    rd("key", TKEY_OFS, 32'h0);
    rd("permit", TPERM_OFS, 32'h0);
    rd("prohibit", STAT_OFS, st(3'b000));
    ftrap <= 1'b1;
    repeat (3) @(posedge clk);
    ftrap <= 1'b0;
    #1;
    chk_bit("ram fetch", 1'b1, srst_b);
    wb(1'b1, STAT_OFS, 8'h0f);
    cause_m = 4'h0;
    rd("cleared", STAT_OFS, st(3'b000));
    wb(1'b1, SC2_OFS, 8'h90);
    pin_reset();
    rd("idle pin", STAT_OFS, st(3'b000));
    tally_and_finish();
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### design/standby_and_reset_control.sv
// standby sequencing and reset combining with a wishbone register slave
// ---------------------------------------------------------------
// Notes on behaviour
// - stop exit: oscillator only, circuits idle
// - warm-up code picks three lengths
// - resume at next instruction after warm-up
// - prescaler and divider restart from zero
// - reset pin low in stop resets
// - idle stops cpu and watchdog only
// - idle keeps memory, registers, latches
// - master off: resume next instruction
// - master on: handler, then next instruction
// - reset pin low in idle resets
// - watchdog interrupt first cancels idle entry
// - four reset causes are combined
// - internal causes not armed by power-on
// - reset clears state, enables watchdog
// - after reset fetch reset vector
// - trap fetch from forbidden area resets
// - trap permitted after reset, key prohibits
// - software interrupt into trap area traps
// - oscillator off or reserved clock resets
// - warm-up counted in clock cycles, doubled
// - stop bit clears on stop exit
// - stop exit rewrites clock bits
// ---------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module standby_and_reset_control #(
  parameter int W00_CYC = sbrc_pkg::WARM_00,
  parameter int W01_CYC = sbrc_pkg::WARM_01,
  parameter int W10_CYC = sbrc_pkg::WARM_10
) (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [sbrc_pkg::ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic O_WB_ACK,
  output logic [31:0] O_WB_DAT,
  input wire logic I_RESET_PIN_B,
  input wire logic I_STOP_RELEASE,
  input wire logic I_WDT_RST,
  input wire logic I_WDT_INT,
  input wire logic I_FETCH_TRAP,
  input wire logic I_SOFT_INT_TRAP,
  input wire logic I_IRQ_PEND,
  input wire logic I_INT_MASTER_EN,
  output logic O_SYS_RST_B,
  output logic O_CPU_HOLD,
  output logic O_WDT_RUN,
  output logic O_OSC_EN,
  output logic O_PRESCALER_CLR,
  output logic O_RESUME_NEXT,
  output logic O_TAKE_IRQ,
  output logic O_VECTOR_FETCH,
  output logic [19:0] O_VECTOR_ADDR
);
  import sbrc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    state_t st;
    logic [7:0] sc1;
    logic [7:0] sc2;
    logic trap_en;
    logic [7:0] key;
    logic [3:0] cause;
    logic [CNT_W-1:0] cnt;
    logic ack;
    logic [7:0] dat;
    logic resume;
    logic irq;
    logic vec;
    logic pclr;
  } ctl_t;

  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(RST_HOLD - 1);
  localparam ctl_t CTL_RST = '{st: ST_RESET, sc1: SC1_RST, sc2: SC2_RST,
    trap_en: 1'b1, key: KEY_RST, cause: 4'h0, cnt: HOLD_LOAD, ack: 1'b0,
    dat: 8'h00, resume: 1'b0, irq: 1'b0, vec: 1'b0, pclr: 1'b1};

  ctl_t s_ff;
  ctl_t nxt_s;
  logic req;
  logic wr;
  logic live;
  logic trap_hit;
  logic clk_off;
  logic int_rst;
  logic rst_any;

  // ---------------------------------------------------------------
  // warm-up length
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] warm_load(input logic [1:0] sel_code,
                                                 input logic dv);
    logic [CNT_W-1:0] n;
    case (sel_code)
      2'b01: n = CNT_W'(W01_CYC);
      2'b10: n = CNT_W'(W10_CYC);
      default: n = CNT_W'(W00_CYC);
    endcase
    if (dv) begin
      n = n << 1;
    end
    return n - 1'b1;
  endfunction

  // ---------------------------------------------------------------
  // bus decode and reset causes
  // ---------------------------------------------------------------
  assign req = I_WB_CYC & I_WB_STB & ~s_ff.ack;
  assign wr = req & I_WB_WE & I_WB_SEL[0] & (s_ff.st != ST_RESET);
  assign live = (s_ff.st == ST_RUN) | (s_ff.st == ST_IDLE);
  assign trap_hit = s_ff.trap_en & (I_FETCH_TRAP | I_SOFT_INT_TRAP);
  assign clk_off = ~s_ff.sc2[OSCEN_BIT] | s_ff.sc2[CLKSEL_BIT];
  assign int_rst = live & (I_WDT_RST | trap_hit | clk_off);
  assign rst_any = ~I_RESET_PIN_B | int_rst;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ack = 1'b0;
    nxt_s.resume = 1'b0;
    nxt_s.irq = 1'b0;
    nxt_s.vec = 1'b0;
    nxt_s.pclr = 1'b0;
    if (req) begin
      nxt_s.ack = 1'b1;
      nxt_s.dat = 8'h00;
      if (I_WB_ADR == SC1_OFS) begin
        nxt_s.dat = s_ff.sc1 & SC1_RMASK;
        if (wr) begin
          nxt_s.sc1 = I_WB_DAT[7:0];
        end
      end else if (I_WB_ADR == SC2_OFS) begin
        nxt_s.dat = s_ff.sc2 & SC2_RMASK;
        if (wr) begin
          nxt_s.sc2 = I_WB_DAT[7:0] & SC2_WMASK;
        end
      end else if (I_WB_ADR == TPERM_OFS) begin
        if (wr) begin
          if (s_ff.key == TRAP_KEY) begin
            nxt_s.trap_en = ~I_WB_DAT[PROHIBIT_BIT];
          end
          nxt_s.key = KEY_RST;
        end
      end else if (I_WB_ADR == TKEY_OFS) begin
        if (wr) begin
          nxt_s.key = I_WB_DAT[7:0];
        end
      end else if (I_WB_ADR == STAT_OFS) begin
        nxt_s.dat = {s_ff.st, s_ff.trap_en, s_ff.cause};
        if (wr) begin
          nxt_s.cause = s_ff.cause & ~I_WB_DAT[3:0];
        end
      end
    end
    case (s_ff.st)
      ST_RUN: begin
        if (s_ff.sc1[STOP_BIT]) begin
          nxt_s.st = ST_STOP;
          nxt_s.pclr = 1'b1;
        end else if (s_ff.sc2[IDLE_BIT]) begin
          if (I_WDT_INT) begin
            nxt_s.sc2[IDLE_BIT] = 1'b0;
            nxt_s.irq = 1'b1;
          end else begin
            nxt_s.st = ST_IDLE;
          end
        end
      end
      ST_STOP: begin
        nxt_s.pclr = 1'b1;
        if (I_STOP_RELEASE) begin
          nxt_s.st = ST_WARM;
          nxt_s.cnt = warm_load(s_ff.sc1[WSEL_LSB+:2], s_ff.sc1[DV_BIT]);
        end
      end
      ST_WARM: begin
        nxt_s.pclr = 1'b1;
        if (s_ff.cnt == '0) begin
          nxt_s.st = ST_RUN;
          nxt_s.resume = 1'b1;
          nxt_s.pclr = 1'b0;
          nxt_s.sc1[STOP_BIT] = 1'b0;
          nxt_s.sc2[OSCEN_BIT] = ~s_ff.sc1[RMODE_BIT];
          nxt_s.sc2[CLKSEL_BIT] = s_ff.sc1[RMODE_BIT];
        end else begin
          nxt_s.cnt = s_ff.cnt - 1'b1;
        end
      end
      ST_IDLE: begin
        if (I_IRQ_PEND) begin
          nxt_s.st = ST_RUN;
          nxt_s.sc2[IDLE_BIT] = 1'b0;
          if (I_INT_MASTER_EN) begin
            nxt_s.irq = 1'b1;
          end else begin
            nxt_s.resume = 1'b1;
          end
        end
      end
      ST_RESET: begin
        nxt_s.pclr = 1'b1;
        if (s_ff.cnt == '0) begin
          nxt_s.st = ST_RUN;
          nxt_s.vec = 1'b1;
          nxt_s.pclr = 1'b0;
        end else begin
          nxt_s.cnt = s_ff.cnt - 1'b1;
        end
      end
      default: begin
        nxt_s.st = ST_RESET;
      end
    endcase
    if (rst_any) begin
      nxt_s.st = ST_RESET;
      nxt_s.cnt = HOLD_LOAD;
      nxt_s.sc1 = SC1_RST;
      nxt_s.sc2 = SC2_RST;
      nxt_s.trap_en = 1'b1;
      nxt_s.key = KEY_RST;
      nxt_s.pclr = 1'b1;
      nxt_s.resume = 1'b0;
      nxt_s.irq = 1'b0;
      nxt_s.vec = 1'b0;
    end
    if (live) begin
      nxt_s.cause[0] = nxt_s.cause[0] | I_WDT_RST;
      nxt_s.cause[1] = nxt_s.cause[1] | trap_hit;
      nxt_s.cause[2] = nxt_s.cause[2] | clk_off;
    end
    nxt_s.cause[3] = nxt_s.cause[3] | ~I_RESET_PIN_B;
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      s_ff <= CTL_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign O_WB_ACK = s_ff.ack;
  assign O_WB_DAT = {24'h000000, s_ff.dat};
  assign O_SYS_RST_B = I_RESET_PIN_B & (s_ff.st != ST_RESET);
  assign O_CPU_HOLD = s_ff.st != ST_RUN;
  assign O_WDT_RUN = s_ff.st == ST_RUN;
  assign O_OSC_EN = s_ff.st != ST_STOP;
  assign O_PRESCALER_CLR = s_ff.pclr;
  assign O_RESUME_NEXT = s_ff.resume;
  assign O_TAKE_IRQ = s_ff.irq;
  assign O_VECTOR_FETCH = s_ff.vec;
  assign O_VECTOR_ADDR = RST_VECTOR;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_warm_idle;
    @(posedge I_MCLK) disable iff (!I_RST_B)
      s_ff.st == ST_WARM |-> O_OSC_EN && O_CPU_HOLD && O_PRESCALER_CLR;
  endproperty
  a_warm_idle: assert property (p_warm_idle) else $error("warm-up not idle");

  property p_warm_len;
    @(posedge I_MCLK) disable iff (!I_RST_B)
      $rose(s_ff.st == ST_WARM) && s_ff.sc1[WSEL_LSB+:2] == 2'b10 && !s_ff.sc1[DV_BIT]
      |-> s_ff.cnt == CNT_W'(W10_CYC - 1);
  endproperty
  a_warm_len: assert property (p_warm_len) else $error("warm-up length wrong");

  property p_warm_dbl;
    @(posedge I_MCLK) disable iff (!I_RST_B)
      $rose(s_ff.st == ST_WARM) && s_ff.sc1[WSEL_LSB+:2] == 2'b01 && s_ff.sc1[DV_BIT]
      |-> s_ff.cnt == CNT_W'(2 * W01_CYC - 1);
  endproperty
  a_warm_dbl: assert property (p_warm_dbl) else $error("doubled warm-up wrong");

  property p_resume;
    @(posedge I_MCLK) disable iff (!I_RST_B)
      s_ff.st == ST_WARM && s_ff.cnt == '0 && I_RESET_PIN_B
      |=> O_RESUME_NEXT && !O_PRESCALER_CLR && !s_ff.sc1[STOP_BIT] && !O_CPU_HOLD;
  endproperty
  a_resume: assert property (p_resume) else $error("stop exit wrong");

  property p_pin_reset;
    @(posedge I_MCLK) disable iff (!I_RST_B)
      !I_RESET_PIN_B |-> !O_SYS_RST_B ##1 s_ff.st == ST_RESET && s_ff.sc2 == SC2_RST;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset missed");

  property p_idle_hold;
    @(posedge I_MCLK) disable iff (!I_RST_B)
      s_ff.st == ST_IDLE |-> O_CPU_HOLD && !O_WDT_RUN && O_OSC_EN;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle hold wrong");

  property p_idle_irq;
    @(posedge I_MCLK) disable iff (!I_RST_B)
      s_ff.st == ST_IDLE && I_IRQ_PEND && !rst_any
      |=> s_ff.st == ST_RUN && (O_TAKE_IRQ == $past(I_INT_MASTER_EN))
          && (O_RESUME_NEXT != $past(I_INT_MASTER_EN));
  endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("idle exit wrong");

  property p_wdt_first;
    @(posedge I_MCLK) disable iff (!I_RST_B)
      s_ff.st == ST_RUN && !s_ff.sc1[STOP_BIT] && s_ff.sc2[IDLE_BIT] && I_WDT_INT && !rst_any
      |=> s_ff.st == ST_RUN && O_TAKE_IRQ;
  endproperty
  a_wdt_first: assert property (p_wdt_first) else $error("idle entered over wdt");

  property p_clk_off;
    @(posedge I_MCLK) disable iff (!I_RST_B)
      s_ff.st == ST_RUN && !s_ff.sc2[OSCEN_BIT] |=> s_ff.st == ST_RESET ##1 s_ff.cause[2];
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock-off reset missed");

  property p_vector;
    @(posedge I_MCLK) disable iff (!I_RST_B)
      $rose(O_SYS_RST_B) && I_RESET_PIN_B |-> O_VECTOR_FETCH && s_ff.trap_en;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector fetch");
endmodule
`default_nettype wire

// ### pkg/sbrc_pkg.sv
// constants, offsets and state encoding of the standby and reset controller
package sbrc_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] SC1_OFS = 8'h00;
  localparam logic [ADR_W-1:0] SC2_OFS = 8'h04;
  localparam logic [ADR_W-1:0] TPERM_OFS = 8'h08;
  localparam logic [ADR_W-1:0] TKEY_OFS = 8'h0c;
  localparam logic [ADR_W-1:0] STAT_OFS = 8'h10;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int STOP_BIT = 7;
  localparam int RMODE_BIT = 6;
  localparam int DV_BIT = 4;
  localparam int WSEL_LSB = 2;
  localparam int OSCEN_BIT = 7;
  localparam int CLKSEL_BIT = 5;
  localparam int IDLE_BIT = 4;
  localparam int PROHIBIT_BIT = 0;
  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] SC1_RST = 8'h00;
  localparam logic [7:0] SC2_RST = 8'h80;
  localparam logic [7:0] SC1_RMASK = 8'hfc;
  localparam logic [7:0] SC2_WMASK = 8'hbf;
  localparam logic [7:0] SC2_RMASK = 8'hb0;
  localparam logic [7:0] KEY_RST = 8'h00;
  // arbitrary unlock value
  localparam logic [7:0] TRAP_KEY = 8'h5a;
  localparam logic [19:0] RST_VECTOR = 20'hffffc;
  // ---------------------------------------------------------------
  // timing counts in high-frequency clock cycles, RST_MCYC in machine cycles of MCYC_FC clocks
  // ---------------------------------------------------------------
  localparam int CNT_W = 19;
  localparam int WARM_00 = 3 * (2 ** 16);
  localparam int WARM_01 = 2 ** 16;
  localparam int WARM_10 = 2 ** 14;
  localparam int MCYC_FC = 4;
  localparam int RST_MCYC = 3;
  localparam int RST_HOLD = RST_MCYC * MCYC_FC;
  // ---------------------------------------------------------------
  // controller states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STOP = 3'b001,
    ST_WARM = 3'b011,
    ST_IDLE = 3'b010,
    ST_RESET = 3'b110
  } state_t;
endpackage
